// file: src/udc_counter.sv
// Purpose: Two-channel 8-bit up/down counter/timer, cascadable to 16 bits
// Assumes: Pins synchronous to i_clk_sys; byte register port
// Notes: Channel 0 pins drive the 16-bit counter in cascade mode
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/100ps
module udc_counter
  import udc_pkg::*;
(
  input wire logic i_clk_sys, // System clock
  input wire logic i_reset, // Async reset, active high
  input wire logic [7:0] i_addr, // Register address
  input wire logic [7:0] i_wdata, // Write data
  input wire logic i_wr, // Write strobe
  input wire logic i_rd, // Read strobe
  output logic [7:0] o_rdata, // Read data, cycle after strobe
  input wire logic [1:0] i_up_pin, // Up count or phase A per channel
  input wire logic [1:0] i_down_pin, // Down count or phase B per channel
  input wire logic [1:0] i_index_gate_input, // Index or gate per channel
  output logic o_irq // Level interrupt
);
  import udc_pkg::*;

  // ************************************************
  // Shared state
  // ************************************************
  logic [2:0] prescale_ff;
  logic [7:0] rdata_ff;
  logic [7:0] irq_mask_ff;
  logic [7:0] irq_stat_ff;
  logic [7:0] nxt_irq_stat;
  logic [7:0] irq_events;
  logic [7:0] irq_clear;
  logic tick_fast;
  logic tick_slow;
  logic m16;
  logic [1:0] carry_out;
  logic [1:0] borrow_out;
  logic [7:0] cnt_rd [2];
  logic [7:0] rc_rd [2];
  logic [7:0] st_rd [2];
  logic [7:0] cl_rd [2];
  logic [7:0] ch_rd [2];

  // ************************************************
  // Prescaler
  // ************************************************
  // prescaler taps
  assign tick_fast = (prescale_ff[0] == 1'b1);
  assign tick_slow = (prescale_ff == 3'h7);

  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      prescale_ff <= PRESCALE_RST;
    end else begin
      prescale_ff <= prescale_ff + 3'h1;
    end
  end

  // ************************************************
  // Channels
  // ************************************************
  // two channels, identical except for cascade
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_ch
      logic [7:0] cnt_ff;
      logic [7:0] rc_ff;
      logic [7:0] st_ff;
      logic [7:0] cl_ff;
      logic [7:0] ch_ff;
      logic [2:0] pin_ff;
      logic pa;
      logic pb;
      logic pz;
      logic pa_prev;
      logic pb_prev;
      logic pz_prev;
      logic a_rise;
      logic a_fall;
      logic b_rise;
      logic b_fall;
      logic [1:0] mode;
      logic [1:0] edge_sel;
      logic casc;
      logic gated_off;
      logic index_clear;
      logic up_ev;
      logic dn_ev;
      logic step_up;
      logic step_dn;
      logic at_max;
      logic at_zero;
      logic cmp_hit;
      logic ovf;
      logic udf;
      logic dir_change;
      logic [7:0] nxt_cnt;
      logic [7:0] nxt_st;
      logic [7:0] nxt_ch;
      logic wr_cnt;
      logic wr_rc;
      logic wr_st;
      logic wr_cl;
      logic wr_ch;
      logic [7:0] cmp_val;
      logic [7:0] rel_val;
      logic cmp_next;
      logic hi_match;
      logic reload_now;
      logic clear_now;

      // ************************************************
      // Pin sampling and edges
      // ************************************************
      // channel 1 follows channel 0 pins in cascade
      assign casc = (g == 1) && m16;
      assign pa = i_up_pin[casc ? 0 : g];
      assign pb = i_down_pin[casc ? 0 : g];
      assign pz = i_index_gate_input[casc ? 0 : g];
      assign {pz_prev, pb_prev, pa_prev} = pin_ff;
      assign a_rise = pa & ~pa_prev;
      assign a_fall = ~pa & pa_prev;
      assign b_rise = pb & ~pb_prev;
      assign b_fall = ~pb & pb_prev;
      assign mode = ch_ff[LSB_MODE +: 2];
      assign edge_sel = ch_ff[LSB_EDGE +: 2];

      // gate function holds counting while index low
      assign gated_off = cl_ff[BIT_INDEX_EN] & cl_ff[BIT_GATE_SEL] & ~pz;
      assign index_clear = cl_ff[BIT_INDEX_EN] & ~cl_ff[BIT_GATE_SEL] & pz;

      // ************************************************
      // Count events
      // ************************************************
      // mode selection of count events
      always_comb begin
        up_ev = 1'b0;
        dn_ev = 1'b0;
        unique case (mode)
          MODE_TIMER: begin
            // timer counts down on prescaler tick
            dn_ev = ch_ff[BIT_CLK_SEL] ? tick_slow : tick_fast;
          end
          MODE_UPDOWN: begin
            // selected edges of up and down pins
            up_ev = ((edge_sel == EDGE_RISE) || (edge_sel == EDGE_BOTH)) & a_rise |
                    ((edge_sel == EDGE_FALL) || (edge_sel == EDGE_BOTH)) & a_fall;
            dn_ev = ((edge_sel == EDGE_RISE) || (edge_sel == EDGE_BOTH)) & b_rise |
                    ((edge_sel == EDGE_FALL) || (edge_sel == EDGE_BOTH)) & b_fall;
          end
          MODE_PHASE_X2: begin
            // count on A edges, direction from B
            up_ev = (a_rise & ~pb) | (a_fall & pb);
            dn_ev = (a_rise & pb) | (a_fall & ~pb);
          end
          MODE_PHASE_X8: begin
            // count on every A and B edge
            up_ev = (a_rise & ~pb) | (a_fall & pb) | (b_rise & pa) | (b_fall & ~pa);
            dn_ev = (a_rise & pb) | (a_fall & ~pb) | (b_rise & ~pa) | (b_fall & pa);
          end
        endcase
      end

      // high byte steps on low byte carry or borrow
      assign step_up = st_ff[BIT_RUN] & ~gated_off &
                       (casc ? carry_out[0] : (up_ev & ~dn_ev));
      assign step_dn = st_ff[BIT_RUN] & ~gated_off &
                       (casc ? borrow_out[0] : (dn_ev & ~up_ev));
      assign at_max = (cnt_ff == 8'hff);
      assign at_zero = (cnt_ff == 8'h00);
      assign ovf = step_up & at_max;
      assign udf = step_dn & at_zero;
      assign carry_out[g] = ovf;
      assign borrow_out[g] = udf;

      // ************************************************
      // Compare and reload
      // ************************************************
      assign cmp_val = rc_ff;
      assign rel_val = rc_ff;
      assign cmp_next = (cnt_ff + 8'h01 == cmp_val);
      // cascade compares the next 16-bit value
      assign hi_match = (g == 1) || !m16 ||
                        (g_ch[1].cnt_ff + {7'h00, carry_out[0]} == g_ch[1].rc_ff);
      // High byte never compares on its own in cascade
      assign cmp_hit = step_up & ~casc & cmp_next & hi_match;
      // cascade low byte reloads only on a 16-bit underflow
      assign reload_now = ((g == 0) && m16) ? (g_ch[1].udf & cl_ff[BIT_RELOAD_EN]) :
                          (udf & cl_ff[BIT_RELOAD_EN]);
      // cascade high byte clears on the 16-bit match
      assign clear_now = casc ? (g_ch[0].cmp_hit & cl_ff[BIT_CLR_ON_CMP]) :
                         (cmp_hit & cl_ff[BIT_CLR_ON_CMP]);
      assign dir_change = (step_up & st_ff[BIT_DIR_LO]) | (step_dn & st_ff[BIT_DIR_HI]);

      assign wr_cnt = i_wr && (i_addr == (g == 0 ? ADDR_COUNT_VALUE_CH0 : ADDR_COUNT_VALUE_CH1));
      assign wr_rc = i_wr && (i_addr == (g == 0 ? ADDR_RELOAD_COMPARE_CH0 : ADDR_RELOAD_COMPARE_CH1));
      assign wr_st = i_wr && (i_addr == (g == 0 ? ADDR_COUNTER_STATE_CH0 : ADDR_COUNTER_STATE_CH1));
      assign wr_cl = i_wr && (i_addr == (g == 0 ? ADDR_COUNTER_CONTROL_LOW_CH0 : ADDR_COUNTER_CONTROL_LOW_CH1));
      assign wr_ch = i_wr && (i_addr == (g == 0 ? ADDR_COUNTER_CONTROL_HIGH_CH0 : ADDR_COUNTER_CONTROL_HIGH_CH1));

      // ************************************************
      // Count value and state
      // ************************************************
      always_comb begin
        nxt_cnt = cnt_ff;
        if (index_clear) begin
          nxt_cnt = RST_BYTE;
        end else if (reload_now) begin
          nxt_cnt = rel_val;
        end else if (clear_now) begin
          nxt_cnt = RST_BYTE;
        end else if (step_up) begin
          nxt_cnt = cnt_ff + 8'h01;
        end else if (step_dn) begin
          nxt_cnt = cnt_ff - 8'h01;
        end
        if (wr_cnt) begin
          nxt_cnt = i_wdata;
        end
      end

      // State register: flags set win over software clear
      always_comb begin
        nxt_st = st_ff;
        if (wr_st) begin
          nxt_st[7:5] = i_wdata[7:5];
          nxt_st[4:2] = st_ff[4:2] & i_wdata[4:2];
        end
        nxt_st[BIT_CMP_F] = nxt_st[BIT_CMP_F] | cmp_hit;
        nxt_st[BIT_OVF_F] = nxt_st[BIT_OVF_F] | ovf;
        nxt_st[BIT_UDF_F] = nxt_st[BIT_UDF_F] | udf;
        if (step_up) begin
          nxt_st[1:0] = 2'h2;
        end else if (step_dn) begin
          nxt_st[1:0] = 2'h1;
        end
      end

      // Control high: direction flag set wins over clear
      always_comb begin
        nxt_ch = ch_ff;
        if (wr_ch) begin
          nxt_ch[BIT_M16] = i_wdata[BIT_M16];
          nxt_ch[BIT_DIRCHG_F] = ch_ff[BIT_DIRCHG_F] & i_wdata[BIT_DIRCHG_F];
          nxt_ch[5:0] = i_wdata[5:0];
        end
        nxt_ch[BIT_DIRCHG_F] = nxt_ch[BIT_DIRCHG_F] | dir_change;
        // Cascade enable exists on channel 0 only
        if (g == 1) begin
          nxt_ch[BIT_M16] = 1'b0;
        end
      end

      // ************************************************
      // Channel registers
      // ************************************************
      always_ff @(posedge i_clk_sys or posedge i_reset) begin
        if (i_reset) begin
          cnt_ff <= RST_BYTE;
          rc_ff <= RST_BYTE;
          st_ff <= RST_BYTE;
          cl_ff <= RST_BYTE;
          ch_ff <= RST_BYTE;
          pin_ff <= 3'h0;
        end else begin
          cnt_ff <= nxt_cnt;
          rc_ff <= wr_rc ? i_wdata : rc_ff;
          st_ff <= nxt_st;
          cl_ff <= wr_cl ? i_wdata : cl_ff;
          ch_ff <= nxt_ch;
          pin_ff <= {pz, pb, pa};
        end
      end

      // ************************************************
      // Interrupt events and read taps
      // ************************************************
      // interrupt enables; underflow and overflow share BIT_UO_IE
      assign irq_events[g*IRQ_PER_CH + IRQ_CMP] = cmp_hit & st_ff[BIT_CMP_IE];
      assign irq_events[g*IRQ_PER_CH + IRQ_UDF] = udf & st_ff[BIT_UO_IE];
      assign irq_events[g*IRQ_PER_CH + IRQ_OVF] = ovf & st_ff[BIT_UO_IE];
      assign irq_events[g*IRQ_PER_CH + IRQ_DIR] = dir_change & ch_ff[BIT_DIRCHG_IE];

      assign cnt_rd[g] = cnt_ff;
      assign rc_rd[g] = rc_ff;
      assign st_rd[g] = st_ff;
      assign cl_rd[g] = cl_ff;
      assign ch_rd[g] = ch_ff;
    end
  endgenerate

  // ************************************************
  // Cascade
  // ************************************************
  // cascade forms a 16-bit counter
  assign m16 = g_ch[0].ch_ff[BIT_M16];

  // ************************************************
  // Interrupt status and mask
  // ************************************************
  logic wr_irq_stat;
  logic wr_irq_mask;

  assign wr_irq_stat = i_wr && (i_addr == ADDR_IRQ_STATUS);
  assign wr_irq_mask = i_wr && (i_addr == ADDR_IRQ_MASK);
  // status is write one to clear, set wins
  assign irq_clear = wr_irq_stat ? i_wdata : 8'h00;
  assign nxt_irq_stat = (irq_stat_ff & ~irq_clear) | irq_events;
  assign o_irq = |(irq_stat_ff & irq_mask_ff);

  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      irq_stat_ff <= RST_BYTE;
      irq_mask_ff <= RST_BYTE;
    end else begin
      irq_stat_ff <= nxt_irq_stat;
      irq_mask_ff <= wr_irq_mask ? i_wdata : irq_mask_ff;
    end
  end

  // ************************************************
  // Read path
  // ************************************************
  logic [7:0] rd_mux;
  logic [7:0] rd_next;
  always_comb begin
    unique case (i_addr)
      ADDR_COUNT_VALUE_CH0: rd_mux = cnt_rd[0];
      ADDR_COUNT_VALUE_CH1: rd_mux = cnt_rd[1];
      ADDR_RELOAD_COMPARE_CH0: rd_mux = rc_rd[0];
      ADDR_RELOAD_COMPARE_CH1: rd_mux = rc_rd[1];
      ADDR_COUNTER_STATE_CH0: rd_mux = st_rd[0];
      ADDR_COUNTER_STATE_CH1: rd_mux = st_rd[1];
      ADDR_COUNTER_CONTROL_LOW_CH0: rd_mux = cl_rd[0];
      ADDR_COUNTER_CONTROL_LOW_CH1: rd_mux = cl_rd[1];
      ADDR_COUNTER_CONTROL_HIGH_CH0: rd_mux = ch_rd[0];
      ADDR_COUNTER_CONTROL_HIGH_CH1: rd_mux = ch_rd[1];
      ADDR_IRQ_MASK: rd_mux = irq_mask_ff;
      ADDR_IRQ_STATUS: rd_mux = irq_stat_ff;
      default: rd_mux = 8'h00;
    endcase
  end

  // Read data stands one cycle only
  assign rd_next = i_rd ? rd_mux : 8'h00;

  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      rdata_ff <= RST_BYTE;
    end else begin
      rdata_ff <= rd_next;
    end
  end
  assign o_rdata = rdata_ff;
endmodule : udc_counter

// file: src/udc_pkg.sv
// Purpose: Constants for the two-channel up/down counter/timer
// Assumes: Byte-wide register port, 20 MHz system clock
// Notes: Offsets are byte addresses on the register port
package udc_pkg;
  // ************************************************
  // Register offsets
  // ************************************************
  localparam logic [7:0] ADDR_COUNT_VALUE_CH0 = 8'h70;
  localparam logic [7:0] ADDR_COUNT_VALUE_CH1 = 8'h71;
  localparam logic [7:0] ADDR_RELOAD_COMPARE_CH0 = 8'h72;
  localparam logic [7:0] ADDR_RELOAD_COMPARE_CH1 = 8'h73;
  localparam logic [7:0] ADDR_COUNTER_STATE_CH0 = 8'h74;
  localparam logic [7:0] ADDR_COUNTER_CONTROL_LOW_CH0 = 8'h76;
  localparam logic [7:0] ADDR_COUNTER_CONTROL_HIGH_CH0 = 8'h77;
  localparam logic [7:0] ADDR_COUNTER_STATE_CH1 = 8'h78;
  localparam logic [7:0] ADDR_COUNTER_CONTROL_LOW_CH1 = 8'h7a;
  localparam logic [7:0] ADDR_COUNTER_CONTROL_HIGH_CH1 = 8'h7b;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h7c;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h7d;
  // ************************************************
  // Counter state fields
  // ************************************************
  localparam int BIT_RUN = 7;
  localparam int BIT_CMP_IE = 6;
  localparam int BIT_UO_IE = 5;
  localparam int BIT_CMP_F = 4;
  localparam int BIT_OVF_F = 3;
  localparam int BIT_UDF_F = 2;
  localparam int BIT_DIR_HI = 1;
  localparam int BIT_DIR_LO = 0;
  // ************************************************
  // Control low fields
  // ************************************************
  localparam int BIT_CLR_ON_CMP = 5;
  localparam int BIT_RELOAD_EN = 4;
  localparam int BIT_GATE_SEL = 2;
  localparam int BIT_INDEX_EN = 0;
  // ************************************************
  // Control high fields
  // ************************************************
  localparam int BIT_M16 = 7;
  localparam int BIT_DIRCHG_F = 6;
  localparam int BIT_DIRCHG_IE = 5;
  localparam int BIT_CLK_SEL = 4;
  localparam int LSB_MODE = 2;
  localparam int LSB_EDGE = 0;
  // ************************************************
  // Interrupt status bits
  // ************************************************
  localparam int IRQ_CMP = 0;
  localparam int IRQ_UDF = 1;
  localparam int IRQ_OVF = 2;
  localparam int IRQ_DIR = 3;
  localparam int IRQ_PER_CH = 4;
  // ************************************************
  // Modes and reset values
  // ************************************************
  localparam logic [1:0] MODE_TIMER = 2'h0;
  localparam logic [1:0] MODE_UPDOWN = 2'h1;
  localparam logic [1:0] MODE_PHASE_X2 = 2'h2;
  localparam logic [1:0] MODE_PHASE_X8 = 2'h3;
  localparam logic [1:0] EDGE_NONE = 2'h0;
  localparam logic [1:0] EDGE_FALL = 2'h1;
  localparam logic [1:0] EDGE_RISE = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam int CLK_DIV_FAST = 2;
  localparam int CLK_DIV_SLOW = 8;
  localparam logic [2:0] PRESCALE_RST = 3'h0;
endpackage : udc_pkg

// file: bench/udc_checker.sv
// Purpose: Port assertions for udc_counter
// Assumes: One clock domain, async active-high reset
// Notes: Mirrors the irq mask to judge o_irq
`timescale 1ns/100ps
module udc_checker
  import udc_pkg::*;
(
  input wire logic i_clk_sys, // Clock
  input wire logic i_reset, // Reset
  input wire logic [7:0] i_addr, // Address
  input wire logic [7:0] i_wdata, // Write data
  input wire logic i_wr, // Write strobe
  input wire logic i_rd, // Read strobe
  input wire logic [7:0] o_rdata, // Read data
  input wire logic [1:0] i_up_pin, // Up pins
  input wire logic [1:0] i_down_pin, // Down pins
  input wire logic [1:0] i_index_gate_input, // Index pins
  input wire logic o_irq // Interrupt
);
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_reset);
  logic [7:0] mask_ff;
  logic [7:0] nxt_mask;
  wire logic mask_wr;
  wire logic unmapped;
  assign mask_wr = i_wr && (i_addr == ADDR_IRQ_MASK);
  assign nxt_mask = mask_wr ? i_wdata : mask_ff;
  assign unmapped = (i_addr < 8'h70) || (i_addr > 8'h7d) || (i_addr inside {8'h75, 8'h79});
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      mask_ff <= 8'h00;
    end else begin
      mask_ff <= nxt_mask;
    end
  end
  // ************************************************
  // Properties
  // ************************************************
  sequence s_wr_rel;
    i_wr && (i_addr == ADDR_RELOAD_COMPARE_CH0);
  endsequence
  sequence s_rd_rel;
    i_rd && (i_addr == ADDR_RELOAD_COMPARE_CH0);
  endsequence
  sequence s_rd_state;
    i_rd && (i_addr == ADDR_COUNTER_STATE_CH0 || i_addr == ADDR_COUNTER_STATE_CH1);
  endsequence
  property p_rel_readback;
    s_wr_rel ##1 s_rd_rel |=> (o_rdata == $past(i_wdata, 2));
  endproperty
  a_rel_readback: assert property (p_rel_readback)
    else $error("reload readback differs from write");
  property p_unmapped;
    i_rd && unmapped |=> (o_rdata == 8'h00);
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  property p_idle_zero;
    !i_rd |=> (o_rdata == 8'h00);
  endproperty
  a_idle_zero: assert property (p_idle_zero)
    else $error("read data without read strobe");
  property p_reset_quiet;
    $fell(i_reset) |-> !o_irq && (o_rdata == 8'h00);
  endproperty
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("outputs busy after reset");
  property p_dir_onehot;
    s_rd_state |=> !(o_rdata[1] && o_rdata[0]);
  endproperty
  a_dir_onehot: assert property (p_dir_onehot)
    else $error("both direction flags set");
  property p_mask_readback;
    mask_wr ##1 (i_rd && i_addr == ADDR_IRQ_MASK) |=> (o_rdata == mask_ff);
  endproperty
  a_mask_readback: assert property (p_mask_readback)
    else $error("mask readback wrong");
  property p_mask_zero_quiet;
    mask_wr && (i_wdata == 8'h00) |=> !o_irq;
  endproperty
  a_mask_zero_quiet: assert property (p_mask_zero_quiet)
    else $error("irq high with zero mask");
  property p_irq_masked;
    o_irq |-> (mask_ff != 8'h00);
  endproperty
  a_irq_masked: assert property (p_irq_masked)
    else $error("irq without any mask bit");
endmodule : udc_checker
bind udc_counter udc_checker u_chk (
  .i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
  .i_rd(i_rd), .o_rdata(o_rdata), .i_up_pin(i_up_pin), .i_down_pin(i_down_pin),
  .i_index_gate_input(i_index_gate_input), .o_irq(o_irq)
);

// file: bench/udc_encoder_model.sv
// Purpose: Quadrature encoder with index for channel 0
// Assumes: One step per cycle with i_fwd or i_rev high
// Notes: Phases hold their level between steps
`timescale 1ns/100ps
module udc_encoder_model (
  input wire logic i_clk_sys, // Clock
  input wire logic i_reset, // Reset
  input wire logic i_fwd, // Step forward
  input wire logic i_rev, // Step backward
  output logic o_phase_a, // Phase A
  output logic o_phase_b, // Phase B
  output logic o_index // Index, high at position zero
);
  logic [1:0] pos_ff;
  logic [1:0] nxt_pos;
  assign nxt_pos = i_fwd ? pos_ff + 2'h1 : (i_rev ? pos_ff - 2'h1 : pos_ff);
  always_ff @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      pos_ff <= 2'h0;
    end else begin
      pos_ff <= nxt_pos;
    end
  end
  assign o_phase_a = pos_ff[1] ^ pos_ff[0];
  assign o_phase_b = pos_ff[1];
  assign o_index = (pos_ff == 2'h0);
endmodule : udc_encoder_model

// file: bench/udc_counter_tb_top.sv
// Purpose: Self-checking bench for udc_counter
// Assumes: 20 MHz clock, bench drives channel 1 pins
// Notes: Channel 0 pins come from the encoder model
`timescale 1ns/100ps
module udc_counter_tb_top;
  import udc_pkg::*;
  logic i_clk_sys, i_reset, i_wr, i_rd, o_irq, fwd, rev, up1, dn1, idx1, enc_a, enc_b, enc_z;
  logic [7:0] i_addr, i_wdata, o_rdata, v, d;
  int n_mismatch, samples_checked, n, e, x;
  int k[4] = '{0, 1, 1, 2};
  udc_counter dut (
    .i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_up_pin({up1, enc_a}),
    .i_down_pin({dn1, enc_b}), .i_index_gate_input({idx1, enc_z}), .o_irq(o_irq)
  );
  udc_encoder_model enc (
    .i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_fwd(fwd), .i_rev(rev),
    .o_phase_a(enc_a), .o_phase_b(enc_b), .o_index(enc_z)
  );
  initial begin
    i_clk_sys = 1'b0;
    forever #25 i_clk_sys = ~i_clk_sys;
  end
  // ************************************************
  // Bus, pin and check tasks
  // ************************************************
  task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [7:0] dt);
    i_wr <= w;
    i_rd <= r;
    i_addr <= a;
    i_wdata <= dt;
    @(posedge i_clk_sys);
  endtask : bus
  task automatic idle(input int c);
    repeat (c) bus(1'b0, 1'b0, 8'h00, 8'h00);
  endtask : idle
  task automatic wr(input logic [7:0] a, input logic [7:0] dt);
    bus(1'b1, 1'b0, a, dt);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    bus(1'b0, 1'b1, a, 8'h00);
    i_rd <= 1'b0;
    // Sample read data once settled
    #1;
    v = o_rdata;
    @(posedge i_clk_sys);
  endtask : rd
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic rdchk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] exp);
    rd(a);
    chk(v & m, exp);
  endtask : rdchk
  task automatic irqchk(input logic exp);
    idle(1);
    #1;
    chk({7'h00, o_irq}, {7'h00, exp});
  endtask : irqchk
  task automatic pulse(input logic u, input logic dw);
    up1 <= u;
    dn1 <= dw;
    idle(2);
    up1 <= 1'b0;
    dn1 <= 1'b0;
    idle(2);
  endtask : pulse
  task automatic step(input logic f, input logic r);
    fwd <= f;
    rev <= r;
    idle(1);
    fwd <= 1'b0;
    rev <= 1'b0;
    idle(2);
  endtask : step
  task automatic end_sim;
    $display("Checked %0d, mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_sim
  initial begin
    repeat (20000) @(posedge i_clk_sys);
    n_mismatch++;
    end_sim();
  end
  // ************************************************
  // Tests
  // ************************************************
  initial begin
    {i_reset, i_wr, i_rd, fwd, rev, up1, dn1, idx1} = 8'h80;
    {i_addr, i_wdata} = 16'h0000;
    n = $urandom(60);
    repeat (6) @(posedge i_clk_sys);
    i_reset <= 1'b0;
    for (e = 8'h70; e < 8'h80; e++) rdchk(8'(e), 8'hff, RST_BYTE);
    wr(8'h75, 8'ha5);
    rdchk(8'h75, 8'hff, 8'h00);
    repeat (3) begin
      d = 8'($urandom);
      wr(8'h72, d);
      rdchk(8'h72, 8'hff, d);
      wr(8'h73, ~d);
      rdchk(8'h73, 8'hff, ~d);
      wr(8'h7c, d);
      rdchk(8'h7c, 8'hff, d);
    end
    wr(8'h7c, 8'h00);
    $display("Test registers done");
    wr(8'h73, 8'hf0);
    for (e = 0; e < 4; e++) begin
      wr(8'h71, 8'h40);
      wr(8'h7b, {4'h0, MODE_UPDOWN, 2'(e)});
      wr(8'h78, 8'h80);
      n = 1 + $urandom % 4;
      repeat (n) pulse(1'b1, 1'b0);
      x = 64 + n * k[e];
      rdchk(8'h71, 8'hff, 8'(x));
    end
    n = 1 + $urandom % 4;
    repeat (n) pulse(1'b0, 1'b1);
    rdchk(8'h71, 8'hff, 8'(x - 2 * n));
    rdchk(8'h78, 8'h03, 8'h01);
    rdchk(8'h7b, 8'h40, 8'h40);
    $display("Test edges done");
    wr(8'h73, 8'h45);
    wr(8'h7a, 8'h30);
    wr(8'h7c, 8'h10);
    for (e = 0; e < 2; e++) begin
      wr(8'h71, 8'h40);
      wr(8'h7b, {4'h0, MODE_UPDOWN, EDGE_RISE});
      wr(8'h78, e ? 8'hc0 : 8'h80);
      repeat (5) pulse(1'b1, 1'b0);
      irqchk(1'(e));
      rdchk(8'h71, 8'hff, 8'h00);
    end
    rdchk(8'h78, 8'h10, 8'h10);
    pulse(1'b0, 1'b1);
    rdchk(8'h71, 8'hff, 8'h45);
    wr(8'h71, 8'hff);
    wr(8'h78, 8'ha0);
    wr(8'h7c, 8'h40);
    pulse(1'b1, 1'b0);
    rdchk(8'h78, 8'h08, 8'h08);
    irqchk(1'b1);
    wr(8'h7d, 8'hff);
    irqchk(1'b0);
    $display("Test compare done");
    wr(8'h7a, 8'h05);
    wr(8'h71, 8'h10);
    repeat (3) pulse(1'b1, 1'b0);
    idx1 <= 1'b1;
    repeat (2) pulse(1'b1, 1'b0);
    rdchk(8'h71, 8'hff, 8'h12);
    wr(8'h7a, 8'h01);
    idle(2);
    rdchk(8'h71, 8'hff, 8'h00);
    idx1 <= 1'b0;
    $display("Test index done");
    for (e = 0; e < 2; e++) begin
      wr(8'h70, 8'h80);
      wr(8'h77, {3'h0, 1'(e), MODE_TIMER, EDGE_NONE});
      wr(8'h74, 8'h80);
      idle(79);
      wr(8'h74, 8'h00);
      rd(8'h70);
      x = 128 - int'(v) - (e ? 80 / CLK_DIV_SLOW : 80 / CLK_DIV_FAST);
      chk({7'h00, x >= -1 && x <= 1}, 8'h01);
    end
    wr(8'h72, 8'h10);
    wr(8'h76, 8'h10);
    wr(8'h70, 8'h02);
    wr(8'h7c, 8'h02);
    wr(8'h77, 8'h00);
    wr(8'h74, 8'ha0);
    idle(9);
    wr(8'h74, 8'h3c);
    rd(8'h70);
    chk({7'h00, v >= 8'h0c && v <= 8'h10}, 8'h01);
    rdchk(8'h74, 8'h04, 8'h04);
    irqchk(1'b1);
    wr(8'h7c, 8'h00);
    irqchk(1'b0);
    wr(8'h7c, 8'h02);
    irqchk(1'b1);
    wr(8'h7d, 8'h02);
    irqchk(1'b0);
    $display("Test timer done");
    wr(8'h76, 8'h00);
    for (e = 2; e < 4; e++) begin
      wr(8'h70, 8'h80);
      wr(8'h77, {4'h2, 2'(e), EDGE_NONE});
      rdchk(8'h77, 8'h0c, {4'h0, 2'(e), 2'h0});
      wr(8'h74, 8'h80);
      repeat (8) step(1'b1, 1'b0);
      rd(8'h70);
      x = (e == 3) ? 8 : 4;
      chk({7'h00, int'(v) == 128 + x || int'(v) == 128 - x}, 8'h01);
      repeat (8) step(1'b0, 1'b1);
      rdchk(8'h70, 8'hff, 8'h80);
      rdchk(8'h77, 8'h40, 8'h40);
      rdchk(8'h7d, 8'h08, 8'h08);
      wr(8'h7d, 8'h08);
    end
    $display("Test phase done");
    wr(8'h7a, 8'h00);
    wr(8'h70, 8'h03);
    wr(8'h71, 8'h00);
    wr(8'h77, 8'h80);
    wr(8'h78, 8'h80);
    wr(8'h74, 8'h80);
    idle(9);
    wr(8'h74, 8'h00);
    wr(8'h78, 8'h00);
    rdchk(8'h71, 8'hff, 8'hff);
    $display("Test cascade done");
    end_sim();
  end
endmodule : udc_counter_tb_top
